//--- rtl/pcs_regs.svh
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH

// Register addresses on the plain register port.
`define PCS_ADDR_CTRL   3'h0
`define PCS_ADDR_BW     3'h1
`define PCS_ADDR_MULH   3'h2
`define PCS_ADDR_MULL   3'h3
`define PCS_ADDR_VRNG   3'h4
`define PCS_ADDR_RDIV   3'h5

// Field positions in pll_control.
`define PCS_CTRL_IRQ_EN 7
`define PCS_CTRL_FLAG   6
`define PCS_CTRL_PLL_ON 5
`define PCS_CTRL_BCS    4
`define PCS_CTRL_PRE_HI 3
`define PCS_CTRL_PRE_LO 2
`define PCS_CTRL_VPR_HI 1
`define PCS_CTRL_VPR_LO 0

// Field positions in bandwidth_control.
`define PCS_BW_AUTO     7
`define PCS_BW_LOCK     6
`define PCS_BW_ACQ      5

// Reset values.
`define PCS_MUL_RESET   12'h040
`define PCS_VRS_RESET   8'h40
`define PCS_RDS_RESET   4'h1
`define PCS_PRE_RESET   2'h0
`define PCS_VPR_RESET   2'h0

// Source edges waited on each side of a clock switchover.
`define PCS_SWITCH_EDGES 2'h3

`endif

//--- rtl/pcs_pkg.sv
`default_nettype none

package pcs_pkg;

  typedef enum logic [2:0] {
    PCS_SW_RUN      = 3'h1,
    PCS_SW_WAIT_OLD = 3'h2,
    PCS_SW_WAIT_NEW = 3'h4
  } pcs_sw_state_t;

  typedef logic [7:0] pcs_byte_t;
  typedef logic [2:0] pcs_addr_t;

endpackage : pcs_pkg

`default_nettype wire

//--- rtl/pcs_clock_ctrl.sv
// What this block does
// - Base clock is VCO-derived clock when select is 1, else oscillator, halved in both cases.
// - Select cannot be set while the PLL enable bit is clear.
// - Clearing the PLL enable bit is ignored while select is set.
// - Switchover waits three old and three new source edges, output held.
// - Prescaler field picks 1, 2, 4 or 8; locked while PLL on.
// - VCO power field picks 1, 2 or 4; locked while PLL on.
// - Bandwidth mode bit: 1 automatic, 0 manual; reset clears it.
// - Lock bit follows lock in automatic mode, reads 0 in manual.
// - Acquire/track bit is status in automatic mode, control in manual.
// - Manual acquire/track value is kept and restored after automatic mode.
// - Twelve-bit multiplier, zero acts as one, resets to 64.
// - Both multiplier registers ignore writes while the PLL is on.
// - VCO centre multiplier ignores writes while PLL on, resets to 64.
// - Zero centre multiplier disables PLL and forces select clear.
// - Four-bit reference divider, locked while PLL on, zero acts as one.
// - Every lock change in automatic mode sets the change flag.
// - In manual mode no interrupt request and the flag reads 0.
// - Select may be set while the lock bit is 0.
// - A read of the control register clears the change flag unless a lock change comes in the same cycle.
// - Interrupt enable ignores writes and reads 0 in manual mode.
// - Reset sets the PLL enable bit.

`include "pcs_regs.svh"

`default_nettype none

module pcs_clock_ctrl (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire pcs_pkg::pcs_addr_t addr,
  input  wire pcs_pkg::pcs_byte_t wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output var  pcs_pkg::pcs_byte_t rdata,
  input  wire logic              osc_clock,
  input  wire logic              divided_vco_clock,
  input  wire logic              vco_lock_in,
  input  wire logic              loop_tracking_in,
  output logic                   base_clock_out,
  output logic                   switch_busy,
  output logic                   pll_active,
  output logic [1:0]             prescaler_select,
  output logic [1:0]             vco_range_power,
  output logic [11:0]            multiplier_eff,
  output logic [7:0]             vco_center_multiplier,
  output logic [3:0]             ref_divider_eff,
  output logic                   auto_bandwidth,
  output logic                   acquire_track_force,
  output logic                   pll_irq_line
);
  import pcs_pkg::*;

  function automatic logic [11:0] pcs_min_one(input logic [11:0] v);
    pcs_min_one = (v == 12'h000) ? 12'h001 : v;
  endfunction : pcs_min_one

  function automatic logic pcs_rising(input logic now, input logic prev);
    pcs_rising = now & ~prev;
  endfunction : pcs_rising

  logic          pll_irq_enable_reg;
  logic          pll_change_flag_reg;
  logic          pll_enable_bit_reg;
  logic          base_clock_select_reg;
  logic [1:0]    prescaler_select_reg;
  logic [1:0]    vco_range_power_reg;
  logic          auto_reg;
  logic          lock_reg;
  logic          acq_shadow_reg;
  logic [11:0]   multiplier_field_reg;
  logic [7:0]    vco_center_reg;
  logic [3:0]    ref_divider_field_reg;
  pcs_byte_t     rdata_reg;
  pcs_byte_t     rdata_next;
  pcs_sw_state_t sw_state_reg;
  logic [1:0]    sw_count_reg;
  logic          active_src_reg;
  logic          base_clk_reg;
  logic          osc_prev_reg;
  logic          vco_prev_reg;

  logic          wr_ctrl;
  logic          wr_bw;
  logic          rd_ctrl;
  logic          vrs_zero;
  logic          lock_change;
  logic          osc_edge;
  logic          vco_edge;
  logic          old_edge;
  logic          new_edge;
  logic          sel_edge;
  logic          acq_status;
  logic [11:0]   rdiv_wide;

  assign wr_ctrl  = wr_stb && (addr == `PCS_ADDR_CTRL);
  assign wr_bw    = wr_stb && (addr == `PCS_ADDR_BW);
  assign rd_ctrl  = rd_stb && (addr == `PCS_ADDR_CTRL);
  assign vrs_zero = (vco_center_reg == 8'h00);

  // The loop is running only with the enable bit set and a usable range.
  assign pll_active = pll_enable_bit_reg && !vrs_zero;

  // PLL enable bit; a clear is refused while the VCO clock is selected,
  // or while the same write selects it.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pll_enable_bit_reg <= 1'b1;
    end
    else if (wr_ctrl)
    begin
      pll_enable_bit_reg <= wdata[`PCS_CTRL_PLL_ON] | base_clock_select_reg
        | (wdata[`PCS_CTRL_BCS] & pll_enable_bit_reg);
    end
  end

  // Base clock select; lock status is deliberately not consulted.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      base_clock_select_reg <= 1'b0;
    end
    else if (vrs_zero)
    begin
      base_clock_select_reg <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      base_clock_select_reg <= wdata[`PCS_CTRL_BCS]
        & pll_enable_bit_reg;
    end
  end

  // Prescaler and VCO power fields, frozen while the PLL is on.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prescaler_select_reg <= `PCS_PRE_RESET;
      vco_range_power_reg  <= `PCS_VPR_RESET;
    end
    else if (wr_ctrl && !pll_enable_bit_reg)
    begin
      prescaler_select_reg <= {wdata[`PCS_CTRL_PRE_HI],
                               wdata[`PCS_CTRL_PRE_LO]};
      vco_range_power_reg  <= {wdata[`PCS_CTRL_VPR_HI],
                               wdata[`PCS_CTRL_VPR_LO]};
    end
  end

  // Interrupt enable, writable only in automatic mode.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pll_irq_enable_reg <= 1'b0;
    end
    else if (wr_ctrl && auto_reg)
    begin
      pll_irq_enable_reg <= wdata[`PCS_CTRL_IRQ_EN];
    end
  end

  // Bandwidth mode bit.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      auto_reg <= 1'b0;
    end
    else if (wr_bw)
    begin
      auto_reg <= wdata[`PCS_BW_AUTO];
    end
  end

  // Lock indicator; writes to its position have no effect here.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lock_reg <= 1'b0;
    end
    else
    begin
      lock_reg <= auto_reg & vco_lock_in;
    end
  end

  assign lock_change = auto_reg && (vco_lock_in != lock_reg);

  // Change flag; a new lock change wins over a clearing read.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pll_change_flag_reg <= 1'b0;
    end
    else if (!auto_reg)
    begin
      pll_change_flag_reg <= 1'b0;
    end
    else if (lock_change)
    begin
      pll_change_flag_reg <= 1'b1;
    end
    else if (rd_ctrl)
    begin
      pll_change_flag_reg <= 1'b0;
    end
  end

  // Manual acquire/track value, kept untouched during automatic mode.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      acq_shadow_reg <= 1'b0;
    end
    else if (wr_bw && !auto_reg)
    begin
      acq_shadow_reg <= wdata[`PCS_BW_ACQ];
    end
  end

  assign acq_status = auto_reg ? loop_tracking_in : acq_shadow_reg;

  // Multiplier, centre multiplier and reference divider, frozen while on.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      multiplier_field_reg  <= `PCS_MUL_RESET;
      vco_center_reg        <= `PCS_VRS_RESET;
      ref_divider_field_reg <= `PCS_RDS_RESET;
    end
    else if (wr_stb && !pll_enable_bit_reg)
    begin
      unique case (addr)
        `PCS_ADDR_MULH:
        begin
          multiplier_field_reg[11:8] <= wdata[3:0];
        end
        `PCS_ADDR_MULL:
        begin
          multiplier_field_reg[7:0] <= wdata;
        end
        `PCS_ADDR_VRNG:
        begin
          vco_center_reg <= wdata;
        end
        `PCS_ADDR_RDIV:
        begin
          ref_divider_field_reg <= wdata[3:0];
        end
        default:
        begin
        end
      endcase
    end
  end

  // Read data, valid in the cycle after the read strobe.
  always_comb
  begin
    rdata_next = 8'h00;
    unique case (addr)
      `PCS_ADDR_CTRL:
      begin
        rdata_next[`PCS_CTRL_IRQ_EN] = pll_irq_enable_reg & auto_reg;
        rdata_next[`PCS_CTRL_FLAG]   = pll_change_flag_reg & auto_reg;
        rdata_next[`PCS_CTRL_PLL_ON] = pll_enable_bit_reg;
        rdata_next[`PCS_CTRL_BCS]    = base_clock_select_reg;
        rdata_next[`PCS_CTRL_PRE_HI] = prescaler_select_reg[1];
        rdata_next[`PCS_CTRL_PRE_LO] = prescaler_select_reg[0];
        rdata_next[`PCS_CTRL_VPR_HI] = vco_range_power_reg[1];
        rdata_next[`PCS_CTRL_VPR_LO] = vco_range_power_reg[0];
      end
      `PCS_ADDR_BW:
      begin
        rdata_next[`PCS_BW_AUTO] = auto_reg;
        rdata_next[`PCS_BW_LOCK] = lock_reg & auto_reg;
        rdata_next[`PCS_BW_ACQ]  = acq_status;
      end
      `PCS_ADDR_MULH:
      begin
        rdata_next[3:0] = multiplier_field_reg[11:8];
      end
      `PCS_ADDR_MULL:
      begin
        rdata_next = multiplier_field_reg[7:0];
      end
      `PCS_ADDR_VRNG:
      begin
        rdata_next = vco_center_reg;
      end
      `PCS_ADDR_RDIV:
      begin
        rdata_next[3:0] = ref_divider_field_reg;
      end
      default:
      begin
        rdata_next = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata_reg <= 8'h00;
    end
    else if (rd_stb)
    begin
      rdata_reg <= rdata_next;
    end
    else
    begin
      rdata_reg <= 8'h00;
    end
  end

  // Source edge detection on the sampled clock inputs.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      osc_prev_reg <= 1'b0;
      vco_prev_reg <= 1'b0;
    end
    else
    begin
      osc_prev_reg <= osc_clock;
      vco_prev_reg <= divided_vco_clock;
    end
  end

  assign osc_edge = pcs_rising(osc_clock, osc_prev_reg);
  // A stopped VCO cannot hold up a switch back to the oscillator.
  assign vco_edge = pcs_rising(divided_vco_clock, vco_prev_reg) | ~pll_active;
  assign old_edge = active_src_reg ? vco_edge : osc_edge;
  assign new_edge = active_src_reg ? osc_edge : vco_edge;
  assign sel_edge = old_edge;

  // Switchover control and the divide-by-two base clock.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sw_state_reg   <= PCS_SW_RUN;
      sw_count_reg   <= 2'h0;
      active_src_reg <= 1'b0;
      base_clk_reg   <= 1'b0;
    end
    else
    begin
      unique case (sw_state_reg)
        PCS_SW_RUN:
        begin
          if (base_clock_select_reg != active_src_reg)
          begin
            sw_state_reg <= PCS_SW_WAIT_OLD;
            sw_count_reg <= 2'h0;
          end
          else if (sel_edge)
          begin
            base_clk_reg <= ~base_clk_reg;
          end
        end
        PCS_SW_WAIT_OLD:
        begin
          if (old_edge)
          begin
            if (sw_count_reg == `PCS_SWITCH_EDGES - 2'h1)
            begin
              sw_state_reg <= PCS_SW_WAIT_NEW;
              sw_count_reg <= 2'h0;
            end
            else
            begin
              sw_count_reg <= sw_count_reg + 2'h1;
            end
          end
        end
        PCS_SW_WAIT_NEW:
        begin
          if (new_edge)
          begin
            if (sw_count_reg == `PCS_SWITCH_EDGES - 2'h1)
            begin
              sw_state_reg   <= PCS_SW_RUN;
              sw_count_reg   <= 2'h0;
              active_src_reg <= ~active_src_reg;
            end
            else
            begin
              sw_count_reg <= sw_count_reg + 2'h1;
            end
          end
        end
        default:
        begin
          sw_state_reg <= PCS_SW_RUN;
          sw_count_reg <= 2'h0;
        end
      endcase
    end
  end

  assign rdata                 = rdata_reg;
  assign base_clock_out        = base_clk_reg;
  assign switch_busy           = (sw_state_reg != PCS_SW_RUN);
  assign prescaler_select      = prescaler_select_reg;
  assign vco_range_power       = vco_range_power_reg;
  assign multiplier_eff        = pcs_min_one(multiplier_field_reg);
  assign vco_center_multiplier = vco_center_reg;
  assign rdiv_wide             = pcs_min_one({8'h00, ref_divider_field_reg});
  assign ref_divider_eff       = rdiv_wide[3:0];
  assign auto_bandwidth        = auto_reg;
  assign acquire_track_force   = acq_shadow_reg;
  assign pll_irq_line          = auto_reg && pll_irq_enable_reg
                                 && pll_change_flag_reg;

endmodule : pcs_clock_ctrl

`default_nettype wire

//--- verif/pcs_clock_ctrl_monitor.sv
`default_nettype none

module pcs_clock_ctrl_monitor (
  input wire logic               clk,
  input wire logic               rstn,
  input wire pcs_pkg::pcs_addr_t addr,
  input wire logic               wr_stb,
  input wire logic               rd_stb,
  input wire pcs_pkg::pcs_byte_t rdata,
  input wire logic               base_clock_out,
  input wire logic               switch_busy,
  input wire logic               pll_active,
  input wire logic [1:0]         prescaler_select,
  input wire logic [11:0]        multiplier_eff,
  input wire logic [7:0]         vco_center_multiplier,
  input wire logic               auto_bandwidth,
  input wire logic               acquire_track_force,
  input wire logic               pll_irq_line
);
  import pcs_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // A switchover that has lasted two cycles.
  sequence s_held;
    switch_busy ##1 switch_busy;
  endsequence
  sequence s_locked_wr(a);
    wr_stb && pll_active && a;
  endsequence
  a_out_frozen: assert property (s_held |-> $stable(base_clock_out))
    else $error("base clock moved during switchover");
  a_switch_ends: assert property (
    $rose(switch_busy) |-> ##[1:100] !switch_busy)
    else $error("switchover did not finish");
  a_irq_auto: assert property (pll_irq_line |-> auto_bandwidth)
    else $error("interrupt in manual mode");
  a_ctrl_manual: assert property (
    rd_stb && addr == 3'h0 && !auto_bandwidth |=> rdata[7:6] == 2'h0)
    else $error("flag or enable read nonzero in manual mode");
  a_bw_manual: assert property (
    rd_stb && addr == 3'h1 && !auto_bandwidth
    |=> rdata == {2'h0, $past(acquire_track_force), 5'h00})
    else $error("bandwidth read wrong in manual mode");
  a_pre_locked: assert property (
    s_locked_wr(addr == 3'h0) |=> $stable(prescaler_select))
    else $error("prescaler changed while PLL on");
  a_mul_locked: assert property (
    s_locked_wr(addr inside {3'h2, 3'h3}) |=> $stable(multiplier_eff))
    else $error("multiplier changed while PLL on");
  a_vrs_locked: assert property (
    s_locked_wr(addr == 3'h4) |=> $stable(vco_center_multiplier))
    else $error("range changed while PLL on");
  a_vrs_zero: assert property (
    vco_center_multiplier == 8'h00 |-> !pll_active)
    else $error("PLL active with zero range");
  a_vrs_no_sel: assert property (
    rd_stb && addr == 3'h0 && vco_center_multiplier == 8'h00
    |=> !rdata[4])
    else $error("clock select set with zero range");
endmodule : pcs_clock_ctrl_monitor

`default_nettype wire

//--- verif/tb_pcs_clock_ctrl.sv
`default_nettype none

`define CHK(g, e) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end

module tb_pcs_clock_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  import pcs_pkg::*;
  logic        clk, rstn, wr_stb, rd_stb;
  logic        osc_clock = 1'b0, divided_vco_clock = 1'b0;
  logic        vco_lock_in, loop_tracking_in, base_clock_out, switch_busy;
  logic        pll_active, auto_bandwidth, acquire_track_force, pll_irq_line;
  pcs_addr_t   addr;
  pcs_byte_t   wdata, rdata;
  logic [1:0]  prescaler_select, vco_range_power;
  logic [11:0] multiplier_eff;
  logic [7:0]  vco_center_multiplier;
  logic [3:0]  ref_divider_eff;
  int          n_errors, checked, osc_cnt, vco_cnt;

  pcs_clock_ctrl u_dut (
    .clk, .rstn, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .osc_clock,
    .divided_vco_clock, .vco_lock_in, .loop_tracking_in, .base_clock_out,
    .switch_busy, .pll_active, .prescaler_select, .vco_range_power,
    .multiplier_eff, .vco_center_multiplier, .ref_divider_eff,
    .auto_bandwidth, .acquire_track_force, .pll_irq_line
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // The oscillator runs at clk/8 and the divided VCO clock at clk/6.
  always @(posedge clk)
  begin
    osc_cnt <= (osc_cnt + 1) % 4;
    vco_cnt <= (vco_cnt + 1) % 3;
    if (osc_cnt == 3)
      osc_clock <= ~osc_clock;
    if (vco_cnt == 2)
      divided_vco_clock <= ~divided_vco_clock;
  end

  task automatic end_of_test;
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task automatic wr(input pcs_addr_t a, input pcs_byte_t d);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rdc(input pcs_addr_t a, input pcs_byte_t e);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    `CHK(rdata, e)
    @(posedge clk);
  endtask : rdc

  task automatic chk_fields(input logic [23:0] e);
    `CHK({multiplier_eff, vco_center_multiplier, ref_divider_eff}, e)
  endtask : chk_fields

  task automatic wait_busy(input logic lvl);
    #1;
    for (int i = 0; i < 100 && switch_busy !== lvl; i++)
    begin
      @(posedge clk);
      #1;
    end
    `CHK(switch_busy, lvl)
    if (switch_busy !== lvl)
      end_of_test();
    else
      @(posedge clk);
  endtask : wait_busy

  // Counts base clock toggles over 96 cycles.
  task automatic count_out(input int lo, input int hi);
    int   n;
    logic prev;
    n = 0;
    prev = base_clock_out;
    repeat (96)
    begin
      @(posedge clk);
      #1;
      n += int'(base_clock_out !== prev);
      prev = base_clock_out;
    end
    `CHK(n >= lo && n <= hi, 1'b1)
    @(posedge clk);
  endtask : count_out

  task automatic t_reset;
    rstn <= 1'b0;
    repeat (8) @(posedge clk);
    chk_fields(24'h0404_01);
    `CHK(base_clock_out, 1'b0)
    `CHK(pll_active, 1'b1)
    rstn <= 1'b1;
    @(posedge clk);
    rdc(3'h0, 8'h20);
    rdc(3'h1, 8'h00);
    rdc(3'h2, 8'h00);
    rdc(3'h3, 8'h40);
    rdc(3'h4, 8'h40);
    rdc(3'h5, 8'h01);
  endtask : t_reset

  task automatic t_protect;
    wr(3'h0, 8'h2E);
    rdc(3'h0, 8'h20);
    wr(3'h2, 8'h0F);
    wr(3'h3, 8'h00);
    wr(3'h4, 8'h00);
    wr(3'h5, 8'h00);
    chk_fields(24'h0404_01);
    wr(3'h0, 8'h0E);
    wr(3'h0, 8'h0E);
    rdc(3'h0, 8'h0E);
    `CHK({prescaler_select, vco_range_power}, 4'hE)
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h00);
    wr(3'h5, 8'h00);
    chk_fields(24'h0014_01);
    wr(3'h7, 8'hFF);
    rdc(3'h7, 8'h00);
    wr(3'h0, 8'h2E);
  endtask : t_protect

  task automatic t_bcs;
    count_out(11, 13);
    wr(3'h0, 8'h0E);
    wr(3'h0, 8'h1E);
    rdc(3'h0, 8'h0E);
    wr(3'h0, 8'h2E);
    wr(3'h0, 8'h3D);
    rdc(3'h0, 8'h3E);
    wait_busy(1'b1);
    wait_busy(1'b0);
    count_out(15, 17);
    wr(3'h0, 8'h1E);
    rdc(3'h0, 8'h3E);
    wr(3'h0, 8'h2E);
    wait_busy(1'b1);
    wait_busy(1'b0);
    wr(3'h0, 8'h0E);
    wr(3'h4, 8'h00);
    wr(3'h0, 8'h2E);
    wr(3'h0, 8'h3E);
    rdc(3'h0, 8'h2E);
    `CHK(pll_active, 1'b0)
    wr(3'h0, 8'h0E);
    wr(3'h4, 8'h40);
    wr(3'h0, 8'h2E);
  endtask : t_bcs

  task automatic t_bw;
    wr(3'h1, 8'h20);
    rdc(3'h1, 8'h20);
    wr(3'h0, 8'hAE);
    rdc(3'h0, 8'h2E);
    wr(3'h1, 8'hA0);
    rdc(3'h1, 8'h80);
    `CHK(acquire_track_force, 1'b1)
    wr(3'h1, 8'h80);
    loop_tracking_in <= 1'b1;
    vco_lock_in <= 1'b1;
    @(posedge clk);
    rdc(3'h1, 8'hE0);
    `CHK(pll_irq_line, 1'b0)
    rdc(3'h0, 8'h6E);
    rdc(3'h0, 8'h2E);
    wr(3'h0, 8'hAE);
    vco_lock_in <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(pll_irq_line, 1'b1)
    @(posedge clk);
    rdc(3'h0, 8'hEE);
    rdc(3'h0, 8'hAE);
    wr(3'h1, 8'h00);
    rdc(3'h1, 8'h20);
    rdc(3'h0, 8'h2E);
    vco_lock_in <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK(pll_irq_line, 1'b0)
    rdc(3'h0, 8'h2E);
  endtask : t_bw

  initial
  begin
    rstn = 1'b0;
    {wr_stb, rd_stb, vco_lock_in, loop_tracking_in} = 4'h0;
    addr = 3'h0;
    wdata = 8'h00;
    {n_errors, checked} = '0;
    t_reset();
    t_protect();
    t_bcs();
    t_bw();
    t_reset();
    end_of_test();
  end
endmodule : tb_pcs_clock_ctrl

bind pcs_clock_ctrl pcs_clock_ctrl_monitor u_mon (
  .clk, .rstn, .addr, .wr_stb, .rd_stb, .rdata, .base_clock_out,
  .switch_busy, .pll_active, .prescaler_select, .multiplier_eff,
  .vco_center_multiplier, .auto_bandwidth, .acquire_track_force,
  .pll_irq_line
);

`default_nettype wire
